// file: pll_pll_loop_config_control_regs.sv
// Synthesizer configuration and status register bank with its small
// digital helpers: feedback divider, lock detect, band clock and probe mux.
// Assumes a register port on ref_clk; ref_in and fb_in are asynchronous pins.
module pll_pll_loop_config_control_regs
	import pll_loop_config_regs_pkg::*;
#(
	parameter int LOCK_TOL = 2
)(
	input  wire logic                       ref_clk,
	input  wire logic                       reset,
	input  wire logic [9:0]                 reg_addr,
	input  wire logic [7:0]                 reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	output logic      [7:0]                 reg_rdata,
	output logic                            reg_rvalid,
	input  wire logic                       ref_in,
	input  wire logic                       fb_in,
	output pll_loop_config_regs_pkg::pll_loop_config_cfg_t      pll_loop_config_cfg,
	output logic      [7:0]                 band_select_ratio,
	output logic                            band_clk,
	output logic                            probe_pin,
	output logic                            rx_mute
);
	import pll_loop_config_regs_pkg::*;

	// ----------------------------------------
	// Register storage
	// ----------------------------------------
	logic        prescale_on_ff;
	logic        feedback_divide_on_ff;
	logic [4:0]  ref_divide_ff;
	logic        ref_multiply_on_ff;
	logic [1:0]  ref_spare_ff;
	logic        ref_halve_on_ff;
	logic [1:0]  lock_check_bias_ff;
	logic [2:0]  lock_window_len_ff;
	logic [2:0]  lock_spare_ff;
	logic [4:0]  settle_limit_ff;
	logic [7:0]  cal_low_ff;
	logic [1:0]  cal_high_ff;
	logic [7:0]  band_ratio_ff;
	logic [1:0]  prescale_bias_ff;
	logic [3:0]  pump_current_ff;
	logic [7:0]  leak_current_ff;
	logic [7:0]  probe_sel_ff;
	logic        mute_unlock_on_ff;
	logic [7:0]  fb_low_stage_ff;
	logic [15:0] fb_word_ff;
	logic [7:0]  rdata_ff;
	logic        rvalid_ff;
	logic [7:0]  nxt_rdata;

	// Live logic
	logic        pfd_tick;
	logic        locked;
	logic        fb_sync1_ff;
	logic        fb_sync2_ff;
	logic        fb_prev_ff;
	logic        fb_rise;
	logic [15:0] fb_cnt_ff;
	logic        fb_tick;
	logic        ref_half_ff;
	logic        fb_half_ff;
	logic [7:0]  band_cnt_ff;
	logic        band_clk_ff;
	logic        probe_ff;
	logic        mute_ff;
	logic [7:0]  band_limit;

	// ----------------------------------------
	// Register writes
	// ----------------------------------------

	// Loop enables; upper bits are read-only zero
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			prescale_on_ff        <= RST_LOOP_CONFIG[LOOP_PRESCALE_BIT];
			feedback_divide_on_ff <= RST_LOOP_CONFIG[LOOP_FB_BIT];
		end else if (reg_wr && reg_addr == OFS_LOOP_CONFIG) begin
			prescale_on_ff        <= reg_wdata[LOOP_PRESCALE_BIT];
			feedback_divide_on_ff <= reg_wdata[LOOP_FB_BIT];
		end
	end

	// Reference divide value
	always_ff @(posedge ref_clk) begin
		if (reset)
			ref_divide_ff <= RST_REF_DIVIDE;
		else if (reg_wr && reg_addr == OFS_REF_DIVIDE)
			ref_divide_ff <= reg_wdata[4:0];
	end

	// Reference path: doubler, writable spare pair, halver
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ref_multiply_on_ff <= RST_REF_PATH[REF_DOUBLE_BIT];
			ref_spare_ff       <= RST_REF_PATH[2:1];
			ref_halve_on_ff    <= RST_REF_PATH[REF_HALVE_BIT];
		end else if (reg_wr && reg_addr == OFS_REF_PATH) begin
			ref_multiply_on_ff <= reg_wdata[REF_DOUBLE_BIT];
			ref_spare_ff       <= reg_wdata[2:1];
			ref_halve_on_ff    <= reg_wdata[REF_HALVE_BIT];
		end
	end

	// Lock check setup; the low spare bits are writable storage
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			lock_check_bias_ff <= RST_LOCK_CHECK[LOCK_BIAS_LSB +: 2];
			lock_window_len_ff <= RST_LOCK_CHECK[LOCK_WIN_LSB +: 3];
			lock_spare_ff      <= RST_LOCK_CHECK[2:0];
		end else if (reg_wr && reg_addr == OFS_LOCK_CHECK) begin
			lock_check_bias_ff <= reg_wdata[LOCK_BIAS_LSB +: 2];
			lock_window_len_ff <= reg_wdata[LOCK_WIN_LSB +: 3];
			lock_spare_ff      <= reg_wdata[2:0];
		end
	end

	// Timeouts and band ratio
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			settle_limit_ff <= RST_SETTLE_LIMIT;
			cal_low_ff      <= RST_CAL_LOW;
			cal_high_ff     <= RST_CAL_HIGH;
			band_ratio_ff   <= RST_BAND_RATIO;
		end else if (reg_wr) begin
			if (reg_addr == OFS_SETTLE_LIMIT)
				settle_limit_ff <= reg_wdata[4:0];
			if (reg_addr == OFS_CAL_LIMIT_LOW)
				cal_low_ff <= reg_wdata;
			if (reg_addr == OFS_CAL_LIMIT_HIGH)
				cal_high_ff <= reg_wdata[1:0];
			if (reg_addr == OFS_BAND_RATIO)
				band_ratio_ff <= reg_wdata;
		end
	end

	// Analog trims; recommended values are left to software
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			prescale_bias_ff <= RST_PRESCALE_BIAS;
			pump_current_ff  <= RST_PUMP_CURRENT;
			leak_current_ff  <= RST_LEAK_CURRENT;
		end else if (reg_wr) begin
			if (reg_addr == OFS_PRESCALE_BIAS)
				prescale_bias_ff <= reg_wdata[1:0];
			if (reg_addr == OFS_PUMP_CURRENT)
				pump_current_ff <= reg_wdata[3:0];
			if (reg_addr == OFS_LEAK_CURRENT)
				leak_current_ff <= reg_wdata;
		end
	end

	// Probe select and mute-on-unlock enable
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			probe_sel_ff      <= RST_PROBE_SELECT;
			mute_unlock_on_ff <= RST_MUTE_UNLOCK;
		end else if (reg_wr) begin
			if (reg_addr == OFS_PROBE_SELECT)
				probe_sel_ff <= reg_wdata;
			if (reg_addr == OFS_MUTE_UNLOCK)
				mute_unlock_on_ff <= reg_wdata[0];
		end
	end

	// Feedback word: low byte is staged, high byte write commits both,
	// so the divider never sees half an update
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			fb_low_stage_ff <= RST_FB_WORD[7:0];
			fb_word_ff      <= RST_FB_WORD;
		end else if (reg_wr) begin
			if (reg_addr == OFS_FB_WORD_LOW)
				fb_low_stage_ff <= reg_wdata;
			if (reg_addr == OFS_FB_WORD_HIGH)
				fb_word_ff <= {reg_wdata, fb_low_stage_ff};
		end
	end

	// ----------------------------------------
	// Register reads
	// ----------------------------------------

	// Reserved bits read back as their fixed values; writes to the lock
	// state never land anywhere
	always_comb begin
		nxt_rdata = 8'h00;
		case (reg_addr)
			OFS_MUTE_UNLOCK:    nxt_rdata = {7'h00, mute_unlock_on_ff};
			OFS_FB_WORD_LOW:    nxt_rdata = fb_low_stage_ff;
			OFS_FB_WORD_HIGH:   nxt_rdata = fb_word_ff[15:8];
			OFS_LOOP_CONFIG:    nxt_rdata = {6'h00, prescale_on_ff, feedback_divide_on_ff};
			OFS_REF_DIVIDE:     nxt_rdata = {3'h0, ref_divide_ff};
			OFS_REF_PATH:       nxt_rdata = {4'h0, ref_multiply_on_ff, ref_spare_ff,
			                                 ref_halve_on_ff};
			OFS_LOCK_CHECK:     nxt_rdata = {lock_check_bias_ff, lock_window_len_ff,
			                                 lock_spare_ff};
			OFS_SETTLE_LIMIT:   nxt_rdata = {3'h0, settle_limit_ff};
			OFS_CAL_LIMIT_LOW:  nxt_rdata = cal_low_ff;
			OFS_CAL_LIMIT_HIGH: nxt_rdata = {6'h00, cal_high_ff};
			OFS_BAND_RATIO:     nxt_rdata = band_ratio_ff;
			OFS_PRESCALE_BIAS:  nxt_rdata = {PRESCALE_RSVD_VAL, prescale_bias_ff};
			OFS_PUMP_CURRENT:   nxt_rdata = {4'h0, pump_current_ff};
			OFS_LEAK_CURRENT:   nxt_rdata = leak_current_ff;
			OFS_LOCK_STATE:     nxt_rdata = {7'h00, locked};
			OFS_PROBE_SELECT:   nxt_rdata = probe_sel_ff;
			default:            nxt_rdata = 8'h00;
		endcase
	end

	// Read data one cycle after the strobe
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rdata_ff  <= 8'h00;
			rvalid_ff <= 1'b0;
		end else begin
			rvalid_ff <= reg_rd;
			if (reg_rd)
				rdata_ff <= nxt_rdata;
		end
	end
	assign reg_rdata  = rdata_ff;
	assign reg_rvalid = rvalid_ff;

	// ----------------------------------------
	// Reference path and lock detector
	// ----------------------------------------
	ref_path u_ref_path (
		.ref_clk    (ref_clk),
		.reset      (reset),
		.ref_in     (ref_in),
		.double_on  (ref_multiply_on_ff),
		.halve_on   (ref_halve_on_ff),
		.divide_val (ref_divide_ff),
		.pfd_tick   (pfd_tick)
	);

	lock_detect #(
		.TOL (LOCK_TOL)
	) u_lock_detect (
		.ref_clk     (ref_clk),
		.reset       (reset),
		.ref_tick    (pfd_tick),
		.fb_tick     (fb_tick),
		.window_code (lock_window_len_ff),
		.locked      (locked)
	);

	// ----------------------------------------
	// Feedback divider
	// ----------------------------------------

	// Feedback pin synchroniser
	always_ff @(posedge ref_clk) begin
		fb_sync1_ff <= reset ? 1'b0 : fb_in;
		fb_sync2_ff <= reset ? 1'b0 : fb_sync1_ff;
		fb_prev_ff  <= reset ? 1'b0 : fb_sync2_ff;
	end
	assign fb_rise = fb_sync2_ff & ~fb_prev_ff;

	// Disabled divider emits no ticks, which also drops lock
	always_ff @(posedge ref_clk) begin
		if (reset || !feedback_divide_on_ff)
			fb_cnt_ff <= 16'h0000;
		else if (fb_rise)
			fb_cnt_ff <= fb_tick ? 16'h0000 : fb_cnt_ff + 16'h0001;
	end
	assign fb_tick = feedback_divide_on_ff && fb_rise && (fb_cnt_ff + 16'h0001 >= fb_word_ff);

	// ----------------------------------------
	// Band select clock and probe
	// ----------------------------------------
	assign band_limit = (band_ratio_ff == 8'h00) ? 8'h01 : band_ratio_ff;

	// Toggles after every band_limit phase detector cycles
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			band_cnt_ff <= 8'h00;
			band_clk_ff <= 1'b0;
		end else if (pfd_tick) begin
			if (band_cnt_ff + 8'h01 >= band_limit) begin
				band_cnt_ff <= 8'h00;
				band_clk_ff <= ~band_clk_ff;
			end else begin
				band_cnt_ff <= band_cnt_ff + 8'h01;
			end
		end
	end

	// Counter halves for the probe
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ref_half_ff <= 1'b0;
			fb_half_ff  <= 1'b0;
		end else begin
			if (pfd_tick)
				ref_half_ff <= ~ref_half_ff;
			if (fb_tick)
				fb_half_ff <= ~fb_half_ff;
		end
	end

	// Probe mux; codes outside the list drive low
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			probe_ff <= 1'b0;
		end else begin
			case (probe_sel_ff[3:0])
				PROBE_LOW:  probe_ff <= 1'b0;
				PROBE_LOCK: probe_ff <= locked;
				PROBE_REF:  probe_ff <= ref_half_ff;
				PROBE_FB:   probe_ff <= fb_half_ff;
				PROBE_HIGH: probe_ff <= 1'b1;
				default:    probe_ff <= 1'b0;
			endcase
		end
	end

	// Receiver mute follows loss of lock when enabled
	always_ff @(posedge ref_clk) begin
		if (reset)
			mute_ff <= RST_MUTE_UNLOCK;
		else
			mute_ff <= mute_unlock_on_ff && !locked;
	end

	// ----------------------------------------
	// Outputs to the analog side
	// ----------------------------------------
	// Fields go straight out so each write acts on the next edge
	assign pll_loop_config_cfg.prescale_on        = prescale_on_ff;
	assign pll_loop_config_cfg.feedback_divide_on = feedback_divide_on_ff;
	assign pll_loop_config_cfg.lock_check_bias    = lock_check_bias_ff;
	assign pll_loop_config_cfg.ref_spare          = ref_spare_ff;
	assign pll_loop_config_cfg.settle_limit       = settle_limit_ff;
	assign pll_loop_config_cfg.osc_cal_limit      = {cal_high_ff, cal_low_ff};
	assign pll_loop_config_cfg.prescale_bias      = prescale_bias_ff;
	assign pll_loop_config_cfg.pump_current       = pump_current_ff;
	assign pll_loop_config_cfg.leak_current       = leak_current_ff;
	assign pll_loop_config_cfg.fb_word            = fb_word_ff;
	assign band_select_ratio            = band_ratio_ff;
	assign band_clk                     = band_clk_ff;
	assign probe_pin                    = probe_ff;
	assign rx_mute                      = mute_ff;

endmodule

// file: pll_loop_config_regs_pkg.sv
// Constants, field layouts and carrier types for the synthesizer register bank.
// Assumes an 8-bit register port with a 10-bit address, all on ref_clk.
//
// Notes on behaviour
// - Loop config: prescaler bit1 off, feedback bit0 on
// - Five-bit reference divide, reset one, divides reference
// - Reference bit3 doubles reference frequency, reset clear
// - Reference bit0 halves; bits 2:1 reset 10
// - Lock after 1024/2048/4096/8192 good cycles
// - Lock state bit0 read-only, one when locked
// - Probe select: low, lock, ref/2, fb/2, high
// - Settle limit five bits, reset 0x1F
// - Ten-bit calibration limit over two registers
// - Band select ratio eight bits, reset 0x10
// - Mute receiver on unlock when enabled
// - Sixteen-bit feedback word double buffered
package pll_loop_config_regs_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [9:0] OFS_MUTE_UNLOCK    = 10'h103;
	localparam logic [9:0] OFS_FB_WORD_LOW    = 10'h200;
	localparam logic [9:0] OFS_FB_WORD_HIGH   = 10'h201;
	localparam logic [9:0] OFS_LOOP_CONFIG    = 10'h20B;
	localparam logic [9:0] OFS_REF_DIVIDE     = 10'h20C;
	localparam logic [9:0] OFS_REF_PATH       = 10'h20E;
	localparam logic [9:0] OFS_LOCK_CHECK     = 10'h214;
	localparam logic [9:0] OFS_SETTLE_LIMIT   = 10'h218;
	localparam logic [9:0] OFS_CAL_LIMIT_LOW  = 10'h21C;
	localparam logic [9:0] OFS_CAL_LIMIT_HIGH = 10'h21D;
	localparam logic [9:0] OFS_BAND_RATIO     = 10'h21E;
	localparam logic [9:0] OFS_PRESCALE_BIAS  = 10'h22B;
	localparam logic [9:0] OFS_PUMP_CURRENT   = 10'h22E;
	localparam logic [9:0] OFS_LEAK_CURRENT   = 10'h22F;
	localparam logic [9:0] OFS_LOCK_STATE     = 10'h24D;
	localparam logic [9:0] OFS_PROBE_SELECT   = 10'h24E;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [1:0]  RST_LOOP_CONFIG   = 2'h1;
	localparam logic [4:0]  RST_REF_DIVIDE    = 5'h01;
	localparam logic [3:0]  RST_REF_PATH      = 4'h4;
	localparam logic [7:0]  RST_LOCK_CHECK    = 8'h48;
	localparam logic [4:0]  RST_SETTLE_LIMIT  = 5'h1F;
	localparam logic [7:0]  RST_CAL_LOW       = 8'h19;
	localparam logic [1:0]  RST_CAL_HIGH      = 2'h0;
	localparam logic [7:0]  RST_BAND_RATIO    = 8'h10;
	localparam logic [1:0]  RST_PRESCALE_BIAS = 2'h1;
	localparam logic [5:0]  PRESCALE_RSVD_VAL = 6'h02;
	localparam logic [3:0]  RST_PUMP_CURRENT  = 4'hE;
	localparam logic [7:0]  RST_LEAK_CURRENT  = 8'h08;
	localparam logic [7:0]  RST_PROBE_SELECT  = 8'h00;
	localparam logic        RST_MUTE_UNLOCK   = 1'b1;
	localparam logic [15:0] RST_FB_WORD       = 16'h0190;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int LOOP_PRESCALE_BIT = 1;
	localparam int LOOP_FB_BIT       = 0;
	localparam int REF_DOUBLE_BIT    = 3;
	localparam int REF_HALVE_BIT     = 0;
	localparam int LOCK_WIN_LSB      = 3;
	localparam int LOCK_BIAS_LSB     = 6;

	// ----------------------------------------
	// Probe codes and lock window
	// ----------------------------------------
	localparam logic [3:0] PROBE_LOW  = 4'h0;
	localparam logic [3:0] PROBE_LOCK = 4'h1;
	localparam logic [3:0] PROBE_REF  = 4'h4;
	localparam logic [3:0] PROBE_FB   = 4'h5;
	localparam logic [3:0] PROBE_HIGH = 4'hE;
	localparam logic [13:0] LOCK_WIN_BASE = 14'd1024;

	// Settings handed to the analog synthesizer
	typedef struct packed {
		logic        prescale_on;
		logic        feedback_divide_on;
		logic [1:0]  lock_check_bias;
		logic [1:0]  ref_spare;
		logic [4:0]  settle_limit;
		logic [9:0]  osc_cal_limit;
		logic [1:0]  prescale_bias;
		logic [3:0]  pump_current;
		logic [7:0]  leak_current;
		logic [15:0] fb_word;
	} pll_loop_config_cfg_t;

endpackage

// file: ref_path.sv
// Reference path: pin synchroniser, doubler, halver and reference divider.
// Assumes ref_in is an asynchronous pin well below half of ref_clk.
module ref_path
	import pll_loop_config_regs_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       reset,
	input  wire logic       ref_in,
	input  wire logic       double_on,
	input  wire logic       halve_on,
	input  wire logic [4:0] divide_val,
	output logic            pfd_tick
);
	logic       sync1_ff;
	logic       sync2_ff;
	logic       prev_ff;
	logic       halve_ff;
	logic [4:0] div_cnt_ff;
	logic       edge_tick;
	logic       half_tick;
	logic [4:0] limit;

	// ----------------------------------------
	// Pin synchroniser
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		sync1_ff <= reset ? 1'b0 : ref_in;
		sync2_ff <= reset ? 1'b0 : sync1_ff;
		prev_ff  <= reset ? 1'b0 : sync2_ff;
	end

	// Both edges count when doubling, rising only otherwise
	assign edge_tick = double_on ? (sync2_ff ^ prev_ff) : (sync2_ff & ~prev_ff);

	// Halver passes every second edge
	always_ff @(posedge ref_clk) begin
		if (reset)
			halve_ff <= 1'b0;
		else if (edge_tick)
			halve_ff <= ~halve_ff;
	end
	assign half_tick = halve_on ? (edge_tick & halve_ff) : edge_tick;

	// Zero would stall the divider, so it acts as one
	assign limit = (divide_val == 5'd0) ? 5'd1 : divide_val;

	// Reference divider ahead of the phase detector
	always_ff @(posedge ref_clk) begin
		if (reset)
			div_cnt_ff <= 5'd0;
		else if (half_tick)
			div_cnt_ff <= (div_cnt_ff + 5'd1 >= limit) ? 5'd0 : div_cnt_ff + 5'd1;
	end
	assign pfd_tick = half_tick && (div_cnt_ff + 5'd1 >= limit);

endmodule

// file: lock_detect.sv
// Digital lock detector: counts consecutive in-tolerance phase detector cycles.
// Assumes one-cycle ref and feedback ticks on ref_clk.
module lock_detect
	import pll_loop_config_regs_pkg::*;
#(
	parameter int TOL = 2
)(
	input  wire logic       ref_clk,
	input  wire logic       reset,
	input  wire logic       ref_tick,
	input  wire logic       fb_tick,
	input  wire logic [2:0] window_code,
	output logic            locked
);
	logic [7:0]  since_ref_ff;
	logic        fb_seen_ff;
	logic [13:0] run_ff;
	logic        locked_ff;
	logic [13:0] target;
	logic        good;
	logic        bad;

	// Codes above 011 saturate at the longest window
	assign target = LOCK_WIN_BASE << (window_code[2] ? 2'd3 : window_code[1:0]);

	// Feedback edge close behind the reference edge is good
	assign good = fb_tick && !fb_seen_ff && (since_ref_ff <= 8'(TOL));
	// Late feedback, or a reference edge with none seen, breaks the run
	assign bad  = (fb_tick && (since_ref_ff > 8'(TOL))) || (ref_tick && !fb_seen_ff && !fb_tick);

	// ----------------------------------------
	// Phase distance tracking
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			since_ref_ff <= 8'hFF;
			fb_seen_ff   <= 1'b1;
		end else if (ref_tick) begin
			since_ref_ff <= 8'h00;
			fb_seen_ff   <= fb_tick;
		end else begin
			if (since_ref_ff != 8'hFF)
				since_ref_ff <= since_ref_ff + 8'h01;
			if (fb_tick)
				fb_seen_ff <= 1'b1;
		end
	end

	// Run length and lock flag
	always_ff @(posedge ref_clk) begin
		if (reset || bad) begin
			run_ff    <= 14'd0;
			locked_ff <= 1'b0;
		end else if (good) begin
			if (run_ff + 14'd1 >= target)
				locked_ff <= 1'b1;
			if (run_ff != 14'h3FFF)
				run_ff <= run_ff + 14'd1;
		end
	end
	assign locked = locked_ff;

endmodule

// file: pll_pll_loop_config_control_regs_monitor.sv
// Port checker for the synthesizer register bank.
// Assumes a bind onto the bank top; sees its ports only, one clock domain.
module pll_pll_loop_config_control_regs_monitor
	import pll_loop_config_regs_pkg::*;
#(
	parameter int LOCK_TOL = 2
)(
	input wire logic                       ref_clk,
	input wire logic                       reset,
	input wire logic [9:0]                 reg_addr,
	input wire logic [7:0]                 reg_wdata,
	input wire logic                       reg_wr,
	input wire logic                       reg_rd,
	input wire logic [7:0]                 reg_rdata,
	input wire logic                       reg_rvalid,
	input wire pll_loop_config_regs_pkg::pll_loop_config_cfg_t pll_loop_config_cfg,
	input wire logic [7:0]                 band_select_ratio,
	input wire logic                       probe_pin
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	// ----------------------------------------
	// Write steps
	// ----------------------------------------
	sequence fb_low_wr;
		reg_wr && reg_addr == OFS_FB_WORD_LOW;
	endsequence
	// Select written, then left alone for one cycle so the mux can settle
	sequence probe_to(logic [3:0] c);
		reg_wr && reg_addr == OFS_PROBE_SELECT && reg_wdata[3:0] == c
		##1 !(reg_wr && reg_addr == OFS_PROBE_SELECT);
	endsequence
	rd_answer_a: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
	rvalid_pulse_a: assert property (!reg_rd |=> !reg_rvalid) else $error("stray rvalid");
	rdata_hold_a: assert property (!reg_rvalid |-> $stable(reg_rdata)) else $error("rdata moved");
	lock_ro_bits_a: assert property (reg_rd && reg_addr == OFS_LOCK_STATE |=>
		reg_rdata[7:1] == 7'h00) else $error("lock state spare bits set");
	settle_write_a: assert property (reg_wr && reg_addr == OFS_SETTLE_LIMIT |=>
		{3'h0, pll_loop_config_cfg.settle_limit} == ($past(reg_wdata) & 8'h1F)) else $error("settle limit");
	loop_write_a: assert property (reg_wr && reg_addr == OFS_LOOP_CONFIG |=>
		{6'h00, pll_loop_config_cfg.prescale_on, pll_loop_config_cfg.feedback_divide_on} ==
		($past(reg_wdata) & 8'h03)) else $error("loop config");
	band_write_a: assert property (reg_wr && reg_addr == OFS_BAND_RATIO |=>
		band_select_ratio == $past(reg_wdata)) else $error("band ratio");
	fb_stage_a: assert property (fb_low_wr |=> $stable(pll_loop_config_cfg.fb_word))
		else $error("feedback word changed on low byte");
	fb_commit_a: assert property (reg_wr && reg_addr == OFS_FB_WORD_HIGH |=>
		pll_loop_config_cfg.fb_word[15:8] == $past(reg_wdata)) else $error("feedback word commit");
	probe_high_a: assert property (probe_to(PROBE_HIGH) |=> probe_pin)
		else $error("probe not high");
	probe_low_a: assert property (probe_to(PROBE_LOW) |=> !probe_pin)
		else $error("probe not low");
endmodule
bind pll_pll_loop_config_control_regs pll_pll_loop_config_control_regs_monitor #(.LOCK_TOL(LOCK_TOL)) mon (
	.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
	.pll_loop_config_cfg(pll_loop_config_cfg), .band_select_ratio(band_select_ratio), .probe_pin(probe_pin));

// file: pll_loop_config_pin_model.sv
// Far-side model: reference oscillator and divided oscillator feedback pins.
// Assumes the bank samples both pins through its own synchronisers.
module pll_loop_config_pin_model #(
	parameter int HALF = 4
)(
	input  wire logic ref_clk,
	input  wire logic fb_on,
	output logic      ref_in,
	output logic      fb_in
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	initial ref_in = 1'b0;
	initial fb_in = 1'b0;
	// Slow square wave; feedback trails one clock, inside the tolerance
	always @(posedge ref_clk) begin
		cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
		if (cnt == HALF - 1) ref_in <= ~ref_in;
		fb_in <= fb_on ? ref_in : 1'b0; // Stalled loop: no feedback edges
	end
endmodule

// file: tb_pll_pll_loop_config_control_regs.sv
// Self-checking bench for the synthesizer register bank.
// Assumes the bound checker and the pin model beside the bank.
module tb_pll_pll_loop_config_control_regs;
	timeunit 1ns;
	timeprecision 1ps;
	import pll_loop_config_regs_pkg::*;
	logic       ref_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, fb_on = 1'b0;
	logic [9:0] reg_addr = 10'h000;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, band_select_ratio;
	logic       reg_rvalid, ref_in, fb_in, probe_pin, rx_mute, band_clk, band_prev = 1'b0;
	pll_loop_config_cfg_t pll_loop_config_cfg;
	int         miscompares = 0, comparisons = 0, cyc = 0, tog, btog = 0;
	localparam logic [9:0] ADR[13] = '{10'h20B, 10'h20C, 10'h20E, 10'h214, 10'h218,
		10'h21C, 10'h21D, 10'h21E, 10'h22B, 10'h22E, 10'h22F, 10'h24D, 10'h24E};
	localparam logic [7:0] RST[13] = '{8'h01, 8'h01, 8'h04, 8'h48, 8'h1F, 8'h19, 8'h00,
		8'h10, 8'h09, 8'h0E, 8'h08, 8'h00, 8'h00};
	localparam logic [7:0] ONES[13] = '{8'h03, 8'h1F, 8'h0F, 8'hFF, 8'h1F, 8'hFF, 8'h03,
		8'hFF, 8'h0B, 8'h0F, 8'hFF, 8'h00, 8'hFF};
	// Probe steps: address, data, toggle range over 128 clocks, static level
	localparam logic [9:0] SA[9] = '{10'h24E, 10'h24E, 10'h24E, 10'h24E, 10'h24E,
		10'h20E, 10'h20E, 10'h20E, 10'h20C};
	localparam logic [7:0] SD[9] = '{8'h01, 8'h0E, 8'h00, 8'h05, 8'h04, 8'h0C, 8'h05, 8'h04, 8'h02};
	localparam int SLO[9] = '{0, 0, 0, 15, 15, 31, 7, 15, 7};
	localparam int SHI[9] = '{0, 0, 0, 17, 17, 33, 9, 17, 9};
	localparam logic SLV[9] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
	pll_pll_loop_config_control_regs #(.LOCK_TOL(2)) dut (
		.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.ref_in(ref_in), .fb_in(fb_in), .pll_loop_config_cfg(pll_loop_config_cfg), .band_clk(band_clk),
		.band_select_ratio(band_select_ratio), .probe_pin(probe_pin), .rx_mute(rx_mute));
	pll_loop_config_pin_model #(.HALF(4)) pins (.ref_clk(ref_clk), .fb_on(fb_on), .ref_in(ref_in),
		.fb_in(fb_in));
	// ----------------------------------------
	// Clock, hang guard and port tasks
	// ----------------------------------------
	always #10 ref_clk = ~ref_clk;
	// Run needs about 11k clocks; the ceiling leaves room
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		// Band clock toggle count, read against a snapshot
		band_prev <= band_clk;
		if (band_clk !== band_prev) btog++;
		if (cyc == 20000) begin
			miscompares++;
			test_done();
		end
	end
	task automatic test_done();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic do_reset();
		@(posedge ref_clk);
		reset <= 1'b1;
		repeat (16) @(posedge ref_clk);
		reset <= 1'b0;
		#1;
	endtask
	// Write ends 1 ns past the taking edge so outputs have landed
	task automatic wr(logic [9:0] a, logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(string what, logic [9:0] a, logic [7:0] e);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		// Answer stands one cycle only, so look just after the taking edge
		#1 chk("rvalid", 16'h0001, {15'h0, reg_rvalid});
		chk(what, {8'h00, e}, {8'h00, reg_rdata});
	endtask
	task automatic step(int i);
		logic last;
		wr(SA[i], SD[i]);
		repeat (2) @(posedge ref_clk);
		#1 last = probe_pin;
		tog = 0;
		repeat (128) begin
			@(posedge ref_clk);
			#1 if (probe_pin !== last) tog++;
			last = probe_pin;
		end
		chk("probe_toggles", 16'h1, {15'h0, tog >= SLO[i] && tog <= SHI[i]});
		if (SHI[i] == 0) chk("probe_level", {15'h0, SLV[i]}, {15'h0, probe_pin});
	endtask
	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		do_reset();
		chk("fb_word", 16'h0190, pll_loop_config_cfg.fb_word);
		for (int i = 0; i < 13; i++) begin
			rd("reset_value", ADR[i], RST[i]);
			wr(ADR[i], 8'hFF);
			rd("ones_value", ADR[i], ONES[i]);
		end
		chk("cal_limit", 16'h03FF, {6'h00, pll_loop_config_cfg.osc_cal_limit});
		chk("trims", 16'hFFFF, {pll_loop_config_cfg.leak_current, pll_loop_config_cfg.prescale_bias,
			pll_loop_config_cfg.lock_check_bias, pll_loop_config_cfg.pump_current});
		chk("band_ratio", 16'h00FF, {8'h00, band_select_ratio});
		rd("unmapped", 10'h3FF, 8'h00);
		$display("register test done");
		do_reset();
		chk("cal_reset", 16'h0019, {6'h00, pll_loop_config_cfg.osc_cal_limit});
		wr(OFS_FB_WORD_LOW, 8'h01);
		chk("fb_staged", 16'h0190, pll_loop_config_cfg.fb_word);
		wr(OFS_FB_WORD_HIGH, 8'h00);
		chk("fb_commit", 16'h0001, pll_loop_config_cfg.fb_word);
		wr(OFS_PRESCALE_BIAS, 8'h03);
		wr(OFS_PUMP_CURRENT, 8'h0E);
		wr(OFS_LEAK_CURRENT, 8'h27);
		wr(OFS_LOCK_CHECK, 8'h40);
		chk("mute_unlocked", 16'h1, {15'h0, rx_mute});
		@(posedge ref_clk) fb_on <= 1'b1;
		repeat (7900) @(posedge ref_clk);
		rd("lock_early", OFS_LOCK_STATE, 8'h00);
		repeat (700) @(posedge ref_clk);
		rd("lock", OFS_LOCK_STATE, 8'h01);
		chk("mute_locked", 16'h0, {15'h0, rx_mute});
		// Ratio 0x10, one tick per 8 clocks: a toggle every 128 clocks
		tog = btog;
		repeat (1280) @(posedge ref_clk);
		chk("band_toggles", 16'h1, {15'h0, (btog - tog) inside {[9:11]}});
		for (int i = 0; i < 5; i++) step(i);
		$display("lock test done");
		@(posedge ref_clk) fb_on <= 1'b0;
		repeat (40) @(posedge ref_clk);
		rd("unlock", OFS_LOCK_STATE, 8'h00);
		chk("mute_lost", 16'h1, {15'h0, rx_mute});
		wr(OFS_MUTE_UNLOCK, 8'h00);
		@(posedge ref_clk);
		#1 chk("mute_off", 16'h0, {15'h0, rx_mute});
		for (int i = 5; i < 9; i++) step(i);
		$display("reference path test done");
		test_done();
	end
endmodule
